// ===== src/faecl_pkg.sv
// package for the flash arbiter with ecc error log
package faecl_pkg;
	localparam int FAECL_ROW_DATA_BYTES = 256;
	localparam int FAECL_ROW_EXTRA_BYTES = 32;
	localparam int FAECL_SECTOR_ROWS = 64;
	localparam int FAECL_NUM_ARRAYS = 4;
	localparam int FAECL_ARRAY_BYTES = 65536;
	localparam int FAECL_ADDR_W = 18;
	localparam int FAECL_ROW_W = 10;
	localparam int FAECL_NUM_LOGS = 6;
	localparam logic [11:0] FAECL_OFF_STATUS = 12'h000;
	localparam logic [11:0] FAECL_OFF_MASK = 12'h004;
	localparam logic [11:0] FAECL_OFF_LOG0 = 12'h010;
	localparam logic [11:0] FAECL_OFF_PROT = 12'h080;
	localparam logic [5:0] FAECL_MASK_RST = 6'h00;
	localparam logic [31:0] FAECL_PROT_RST = 32'h00000000;
	localparam int FAECL_LOG_VALID_BIT = 31;
	// log index assignment
	localparam int FAECL_LOG_SBE = 0;
	localparam int FAECL_LOG_MBE = 1;
	localparam int FAECL_LOG_HUBW = 2;
	localparam int FAECL_LOG_DBGP = 3;
	localparam int FAECL_LOG_BOOTP = 4;
	localparam int FAECL_LOG_ACCW = 5;
	localparam logic [1:0] FAECL_SIZE_BYTE = 2'h0;
	localparam logic [1:0] FAECL_SIZE_HALF = 2'h1;
	localparam logic [1:0] FAECL_SIZE_WORD = 2'h2;

	typedef enum logic [1:0]
	{
		FAECL_OP_READ = 2'h0,
		FAECL_OP_PROGRAM = 2'h1,
		FAECL_OP_ERASE_SECTOR = 2'h2,
		FAECL_OP_ERASE_ALL = 2'h3
	} faecl_op_t;

	typedef enum logic [2:0]
	{
		FAECL_ST_IDLE = 3'b001,
		FAECL_ST_CACHE = 3'b010,
		FAECL_ST_NVPC = 3'b100
	} faecl_state_t;

	typedef struct packed
	{
		logic req;
		faecl_op_t op;
		logic [1:0] size;
		logic [FAECL_ADDR_W-1:0] addr;
		logic [31:0] wdata;
		logic debug_host;
		logic boot_loader;
	} faecl_nvpc_req_t;

	typedef struct packed
	{
		logic req;
		logic [1:0] size;
		logic [FAECL_ADDR_W-1:0] addr;
	} faecl_cache_req_t;

	typedef struct packed
	{
		logic sel;
		logic write;
		faecl_op_t op;
		logic [1:0] size;
		logic [FAECL_ADDR_W-1:0] addr;
		logic [31:0] wdata;
	} faecl_flash_cmd_t;
endpackage

// ===== src/faecl_top.sv
// flash access arbiter, ecc fill check and error log with axi4-lite slave
// Operation
// - flash row is 256 data bytes plus 32 ecc or extra bytes
// - reads allowed at byte, halfword and word widths
// - erase by 64-row sector or whole flash; program one row
// - cache gets reads only; programming controller reads and writes
// - only one requester owns the flash at a time
// - cache request stalls while programming controller owns flash
// - programming request stalls while cache owns flash
// - cpu fetch stalls until cache fill from flash completes
// - up to four arrays of 64 KB, one arbiter for all
// - row protection gates debug host access and boot reprogram; rows 16 apart share protection bits
// - flash readable by cpu through cache and by programming controller
// - each error captured in own log, latched until cleared
// - masked error sources merge into one interrupt request
// - summary status shows all log valid bits in one read
// - reading log registers zero to five clears them
// - summary bits follow log valid bits, not stored
// - logging always on, except fill error logs need ecc_enable; mask only gates the interrupt
// - single-bit fill error corrected and logged
// - multi-bit fill error logged, data not repaired
// - write attempts through peripheral hub are logged
//
// Implementation choices: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
module faecl_top
	import faecl_pkg::*;
(
	input wire logic clk,
	input wire logic srst,
	input wire logic clk_en,
	input wire faecl_cache_req_t cache_req,
	output logic cache_gnt,
	output logic cache_done,
	output logic [31:0] cache_rdata,
	output logic cpu_fetch_stall,
	input wire faecl_nvpc_req_t nvpc_req,
	output logic nvpc_gnt,
	output logic nvpc_done,
	output logic nvpc_refused,
	output logic [31:0] nvpc_rdata,
	output faecl_flash_cmd_t flash_cmd,
	input wire logic flash_done,
	input wire logic [31:0] flash_rdata,
	input wire logic [6:0] flash_ecc,
	input wire logic ecc_enable,
	input wire logic hub_wr_attempt,
	input wire logic [FAECL_ADDR_W-1:0] hub_wr_addr,
	output logic irq,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	// codeword position of data bit i; powers of two hold check bits
	function automatic logic [5:0] data_pos(input int i);
		int n;
		logic [5:0] p;
		n = 0;
		p = 6'h00;
		for (int k = 3; k < 39; k++)
		begin
			if ((k & (k - 1)) != 0)
			begin
				if (n == i)
					p = 6'(k);
				n++;
			end
		end
		return p;
	endfunction

	// hamming(38,32) plus overall parity over the fetched word
	function automatic logic [6:0] ecc_gen(input logic [31:0] d);
		logic [6:0] c;
		logic [5:0] p;
		c = 7'h00;
		for (int i = 0; i < 32; i++)
		begin
			p = data_pos(i);
			for (int b = 0; b < 6; b++)
			begin
				if (p[b])
					c[b] = c[b] ^ d[i];
			end
		end
		c[6] = ^d ^ (^c[5:0]);
		return c;
	endfunction

	function automatic logic [FAECL_ROW_W-1:0] row_of(
		input logic [FAECL_ADDR_W-1:0] a);
		return a[FAECL_ADDR_W-1:8];
	endfunction

	faecl_state_t state_reg;
	faecl_state_t state_next;
	faecl_cache_req_t cache_hold_reg;
	faecl_nvpc_req_t nvpc_hold_reg;
	logic [5:0] mask_reg;
	logic [31:0] log_reg [FAECL_NUM_LOGS];
	logic [31:0] prot_reg [32];
	logic [FAECL_NUM_LOGS-1:0] log_valid;
	logic [FAECL_NUM_LOGS-1:0] log_set;
	logic [FAECL_NUM_LOGS-1:0] log_clr;
	logic [30:0] log_info [FAECL_NUM_LOGS];
	logic [6:0] syn;
	logic [6:0] ecc_calc;
	logic sbe;
	logic mbe;
	logic [31:0] fixed_data;
	logic nvpc_ok;
	logic row_dbg_lock;
	logic row_boot_lock;
	logic nvpc_write;

	// protection: bit pair per row, even debug lock, odd boot lock; rows r and r+16 in a 32-row register share a pair
	always_comb
	begin
		logic [FAECL_ROW_W-1:0] r;
		r = row_of(nvpc_req.addr);
		row_dbg_lock = prot_reg[r[FAECL_ROW_W-1:5]][{r[3:0], 1'b0}];
		row_boot_lock = prot_reg[r[FAECL_ROW_W-1:5]][{r[3:0], 1'b1}];
	end

	assign nvpc_write = nvpc_req.op != FAECL_OP_READ;
	assign nvpc_ok = !(nvpc_req.debug_host && row_dbg_lock)
		&& !(nvpc_req.boot_loader && nvpc_write && row_boot_lock);

	// arbiter: owner keeps flash until flash_done; the other waits
	always_comb
	begin
		state_next = state_reg;
		unique case (state_reg)
			FAECL_ST_IDLE:
			begin
				if (nvpc_req.req && nvpc_ok)
					state_next = FAECL_ST_NVPC;
				else if (cache_req.req)
					state_next = FAECL_ST_CACHE;
			end
			FAECL_ST_CACHE:
			begin
				if (flash_done)
					state_next = (nvpc_req.req && nvpc_ok) ? FAECL_ST_NVPC
						: cache_req.req ? FAECL_ST_CACHE : FAECL_ST_IDLE;
			end
			FAECL_ST_NVPC:
			begin
				if (flash_done)
					state_next = cache_req.req ? FAECL_ST_CACHE
						: (nvpc_req.req && nvpc_ok) ? FAECL_ST_NVPC
						: FAECL_ST_IDLE;
			end
			default:
				state_next = FAECL_ST_IDLE;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			state_reg <= FAECL_ST_IDLE;
		else if (clk_en)
			state_reg <= state_next;
	end

	wire grant_cache = clk_en && state_next == FAECL_ST_CACHE
		&& (state_reg != FAECL_ST_CACHE || flash_done);
	wire grant_nvpc = clk_en && state_next == FAECL_ST_NVPC
		&& (state_reg != FAECL_ST_NVPC || flash_done);
	assign cache_gnt = grant_cache;
	assign nvpc_gnt = grant_nvpc;
	assign nvpc_refused = nvpc_req.req && !nvpc_ok;

	// latch requests at grant; requester may drop them afterwards
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			cache_hold_reg <= '0;
			nvpc_hold_reg <= '0;
		end
		else if (clk_en)
		begin
			if (grant_cache)
				cache_hold_reg <= cache_req;
			if (grant_nvpc)
				nvpc_hold_reg <= nvpc_req;
		end
	end

	always_comb
	begin
		flash_cmd = '0;
		if (state_reg == FAECL_ST_CACHE)
		begin
			flash_cmd.sel = 1'b1;
			flash_cmd.write = 1'b0;
			flash_cmd.op = FAECL_OP_READ;
			flash_cmd.size = cache_hold_reg.size;
			flash_cmd.addr = cache_hold_reg.addr;
		end
		else if (state_reg == FAECL_ST_NVPC)
		begin
			flash_cmd.sel = 1'b1;
			flash_cmd.write = nvpc_hold_reg.op != FAECL_OP_READ;
			flash_cmd.op = nvpc_hold_reg.op;
			flash_cmd.size = nvpc_hold_reg.size;
			flash_cmd.addr = nvpc_hold_reg.op == FAECL_OP_ERASE_SECTOR
				? {nvpc_hold_reg.addr[FAECL_ADDR_W-1:14], 14'h0000}
				: nvpc_hold_reg.op == FAECL_OP_PROGRAM
				? {nvpc_hold_reg.addr[FAECL_ADDR_W-1:8], 8'h00}
				: nvpc_hold_reg.addr;
			flash_cmd.wdata = nvpc_hold_reg.wdata;
		end
	end

	// ecc check on cache fills
	assign ecc_calc = ecc_gen(flash_rdata);
	// parity over every received bit, so a check-bit flip counts as single
	assign syn = {^{flash_rdata, flash_ecc}, ecc_calc[5:0] ^ flash_ecc[5:0]};
	wire fill_end = clk_en && state_reg == FAECL_ST_CACHE && flash_done;
	assign sbe = ecc_enable && syn[6] && syn != 7'h00;
	assign mbe = ecc_enable && !syn[6] && syn[5:0] != 6'h00;
	always_comb
	begin
		fixed_data = flash_rdata;
		for (int i = 0; i < 32; i++)
		begin
			if (sbe && syn[5:0] == data_pos(i))
				fixed_data[i] = ~flash_rdata[i];
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			cache_rdata <= 32'h00000000;
			cache_done <= 1'b0;
			nvpc_rdata <= 32'h00000000;
			nvpc_done <= 1'b0;
		end
		else if (clk_en)
		begin
			cache_done <= fill_end;
			nvpc_done <= state_reg == FAECL_ST_NVPC && flash_done;
			if (fill_end)
				cache_rdata <= fixed_data;
			if (state_reg == FAECL_ST_NVPC && flash_done)
				nvpc_rdata <= flash_rdata;
		end
	end

	assign cpu_fetch_stall = cache_req.req || state_reg == FAECL_ST_CACHE;

	// error log sources
	always_comb
	begin
		for (int i = 0; i < FAECL_NUM_LOGS; i++)
			log_info[i] = '0;
		log_set = '0;
		log_set[FAECL_LOG_SBE] = fill_end && sbe;
		log_info[FAECL_LOG_SBE] = 31'({syn, cache_hold_reg.addr});
		log_set[FAECL_LOG_MBE] = fill_end && mbe;
		log_info[FAECL_LOG_MBE] = 31'({syn, cache_hold_reg.addr});
		log_set[FAECL_LOG_HUBW] = clk_en && hub_wr_attempt;
		log_info[FAECL_LOG_HUBW] = 31'(hub_wr_addr);
		log_set[FAECL_LOG_DBGP] = clk_en && nvpc_req.req
			&& nvpc_req.debug_host && row_dbg_lock;
		log_info[FAECL_LOG_DBGP] = 31'(nvpc_req.addr);
		log_set[FAECL_LOG_BOOTP] = clk_en && nvpc_req.req
			&& nvpc_req.boot_loader && nvpc_write && row_boot_lock;
		log_info[FAECL_LOG_BOOTP] = 31'(nvpc_req.addr);
		log_set[FAECL_LOG_ACCW] = 1'b0;
		log_info[FAECL_LOG_ACCW] = '0;
	end

	// axi4-lite slave; single outstanding write and read
	logic aw_have_reg;
	logic w_have_reg;
	logic [11:0] awaddr_reg;
	logic [31:0] wdata_reg;
	logic [3:0] wstrb_reg;
	assign s_axi_awready = !aw_have_reg && !s_axi_bvalid;
	assign s_axi_wready = !w_have_reg && !s_axi_bvalid;
	wire wr_go = aw_have_reg && w_have_reg && !s_axi_bvalid;
	wire rd_go = s_axi_arvalid && s_axi_arready;
	assign s_axi_arready = !s_axi_rvalid;

	function automatic logic [31:0] merge(input logic [31:0] o,
		input logic [31:0] n, input logic [3:0] s);
		logic [31:0] r;
		r = o;
		for (int b = 0; b < 4; b++)
		begin
			if (s[b])
				r[8*b +: 8] = n[8*b +: 8];
		end
		return r;
	endfunction

	logic [31:0] mask_merged;
	assign mask_merged = merge({26'h0, mask_reg}, wdata_reg, wstrb_reg);

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			aw_have_reg <= 1'b0;
			w_have_reg <= 1'b0;
			awaddr_reg <= 12'h000;
			wdata_reg <= 32'h00000000;
			wstrb_reg <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
		end
		else if (clk_en)
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_have_reg <= 1'b1;
				awaddr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_have_reg <= 1'b1;
				wdata_reg <= s_axi_wdata;
				wstrb_reg <= s_axi_wstrb;
			end
			if (wr_go)
			begin
				aw_have_reg <= 1'b0;
				w_have_reg <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (awaddr_reg == FAECL_OFF_MASK
					|| awaddr_reg[11:7] == FAECL_OFF_PROT[11:7]) ? 2'h0 : 2'h2;
			end
			else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			mask_reg <= FAECL_MASK_RST;
		else if (clk_en && wr_go && awaddr_reg == FAECL_OFF_MASK)
			mask_reg <= mask_merged[5:0];
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			for (int i = 0; i < 32; i++)
				prot_reg[i] <= FAECL_PROT_RST;
		end
		else if (clk_en && wr_go && awaddr_reg[11:7] == FAECL_OFF_PROT[11:7])
			prot_reg[awaddr_reg[6:2]] <=
				merge(prot_reg[awaddr_reg[6:2]], wdata_reg, wstrb_reg);
	end

	// read clears a log; a new event in the same cycle wins
	always_comb
	begin
		for (int i = 0; i < FAECL_NUM_LOGS; i++)
			log_clr[i] = rd_go && s_axi_araddr == FAECL_OFF_LOG0
				+ 12'(4 * i);
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			for (int i = 0; i < FAECL_NUM_LOGS; i++)
				log_reg[i] <= 32'h00000000;
		end
		else if (clk_en)
		begin
			for (int i = 0; i < FAECL_NUM_LOGS; i++)
			begin
				if (log_set[i] && !log_valid[i])
					log_reg[i] <= {1'b1, log_info[i]};
				else if (log_set[i] && log_clr[i])
					log_reg[i] <= {1'b1, log_info[i]};
				else if (log_clr[i])
					log_reg[i] <= 32'h00000000;
			end
		end
	end

	always_comb
	begin
		for (int i = 0; i < FAECL_NUM_LOGS; i++)
			log_valid[i] = log_reg[i][FAECL_LOG_VALID_BIT];
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= 2'h0;
		end
		else if (clk_en)
		begin
			if (rd_go)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= 2'h0;
				s_axi_rdata <= 32'h00000000;
				if (s_axi_araddr == FAECL_OFF_STATUS)
					s_axi_rdata <= {26'h0, log_valid};
				else if (s_axi_araddr == FAECL_OFF_MASK)
					s_axi_rdata <= {26'h0, mask_reg};
				else if (s_axi_araddr >= FAECL_OFF_LOG0
					&& s_axi_araddr < FAECL_OFF_LOG0 + 12'h018
					&& s_axi_araddr[1:0] == 2'h0)
					s_axi_rdata <= log_reg[3'(
						(s_axi_araddr - FAECL_OFF_LOG0) >> 2)];
				else if (s_axi_araddr[11:7] == FAECL_OFF_PROT[11:7])
					s_axi_rdata <= prot_reg[s_axi_araddr[6:2]];
				else
					s_axi_rresp <= 2'h2;
			end
			else if (s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

	// level request, follows the log valid bits directly
	assign irq = |(log_valid & mask_reg);
endmodule

// ===== test/faecl_flash_model.sv
// flash array model: answers each command after a set busy time
`timescale 1ns/1ps
module faecl_flash_model
	import faecl_pkg::*;
(
	input wire logic clk,
	input wire logic srst,
	input wire faecl_flash_cmd_t flash_cmd,
	input wire logic [3:0] lat,
	input wire logic [31:0] err,
	output logic flash_done,
	output logic [31:0] flash_rdata,
	output logic [6:0] flash_ecc
);
	logic [3:0] cnt_reg;
	logic [7:0] junk_reg;
	always_ff @(posedge clk)
		if (srst || !flash_cmd.sel || flash_done)
			cnt_reg <= 4'h0;
		else
			cnt_reg <= cnt_reg + 4'h1;
	// noise outside done, so stale data can never pass as good
	always_ff @(posedge clk)
		junk_reg <= srst ? 8'hA5 : junk_reg + 8'h5B;
	assign flash_done = flash_cmd.sel && cnt_reg == lat;
	// stored word is zero with zero check bits; err flips data bits
	assign flash_rdata = flash_done ? err : {4{junk_reg}};
	assign flash_ecc = flash_done ? 7'h00 : junk_reg[6:0];
endmodule

// ===== test/faecl_sva.sv
// concurrent checks on the arbiter and error log ports
`timescale 1ns/1ps
module faecl_sva
	import faecl_pkg::*;
(
	input wire logic clk,
	input wire logic srst,
	input wire faecl_cache_req_t cache_req,
	input wire logic cache_gnt,
	input wire logic cache_done,
	input wire logic cpu_fetch_stall,
	input wire faecl_nvpc_req_t nvpc_req,
	input wire logic nvpc_gnt,
	input wire logic nvpc_refused,
	input wire faecl_flash_cmd_t flash_cmd,
	input wire logic flash_done,
	input wire logic irq,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_wvalid
);
	logic c_own_reg;
	logic n_own_reg;
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	// owner from grant until the flash reports done
	always_ff @(posedge clk)
		if (srst)
			c_own_reg <= 1'b0;
		else if (cache_gnt)
			c_own_reg <= 1'b1;
		else if (flash_done)
			c_own_reg <= 1'b0;
	always_ff @(posedge clk)
		if (srst)
			n_own_reg <= 1'b0;
		else if (nvpc_gnt)
			n_own_reg <= 1'b1;
		else if (flash_done)
			n_own_reg <= 1'b0;
	sequence cache_end; c_own_reg && flash_done; endsequence
	sequence nvpc_end; n_own_reg && flash_done; endsequence
	one_owner_a: assert property (!(c_own_reg && n_own_reg)
		&& !(cache_gnt && nvpc_gnt)) else $error("two flash owners");
	cache_rdonly_a: assert property (c_own_reg |-> !flash_cmd.write)
		else $error("cache wrote flash");
	fetch_stall_a: assert property (c_own_reg |-> cpu_fetch_stall)
		else $error("fetch ran during fill");
	cache_wait_a: assert property (n_own_reg && !flash_done |-> !cache_gnt)
		else $error("cache granted early");
	nvpc_wait_a: assert property (c_own_reg && !flash_done |-> !nvpc_gnt)
		else $error("programmer granted early");
	to_nvpc_a: assert property (cache_end ##0
		(nvpc_req.req && !nvpc_refused) |-> nvpc_gnt) else $error("no handover");
	to_cache_a: assert property (nvpc_end ##0 cache_req.req |-> cache_gnt)
		else $error("no handover to cache");
	fill_done_a: assert property (cache_end |=> cache_done)
		else $error("fill done late");
	irq_hold_a: assert property ($fell(irq) |-> $past(s_axi_arvalid)
		|| $past(s_axi_arvalid, 2) || $past(s_axi_wvalid, 2)
		|| $past(s_axi_wvalid, 3)) else $error("irq dropped by itself");
endmodule
bind faecl_top faecl_sva i_sva (.clk, .srst, .cache_req, .cache_gnt,
	.cache_done, .cpu_fetch_stall, .nvpc_req, .nvpc_gnt, .nvpc_refused,
	.flash_cmd, .flash_done, .irq, .s_axi_arvalid, .s_axi_wvalid);

// ===== test/test_faecl_top.sv
// bench for the flash arbiter: bus, fills, contention and error log
`timescale 1ns/1ps
module test_faecl_top
	import faecl_pkg::*;
;
	logic clk, srst, ecc_enable, hub_wr_attempt, irq, flash_done;
	logic cache_gnt, cache_done, cpu_fetch_stall, nvpc_gnt, nvpc_done;
	logic clk_en, nvpc_refused;
	logic [31:0] nvpc_rdata;
	logic [17:0] hub_wr_addr;
	logic [3:0] lat;
	logic [6:0] flash_ecc;
	logic [31:0] err, cache_rdata, flash_rdata, s_axi_wdata, s_axi_rdata;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready;
	faecl_cache_req_t cache_req;
	faecl_nvpc_req_t nvpc_req;
	faecl_flash_cmd_t flash_cmd;
	int n_mismatch = 0;
	int total_checks = 0;
	int cyc = 0;
	faecl_top i_dut (.clk, .srst, .clk_en, .cache_req, .cache_gnt,
		.cache_done, .cache_rdata, .cpu_fetch_stall, .nvpc_req, .nvpc_gnt,
		.nvpc_done, .nvpc_refused, .nvpc_rdata, .flash_cmd, .flash_done,
		.flash_rdata, .flash_ecc, .ecc_enable, .hub_wr_attempt, .hub_wr_addr,
		.irq, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready);
	faecl_flash_model i_flash (.clk, .srst, .flash_cmd, .lat, .err,
		.flash_done, .flash_rdata, .flash_ecc);
	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	task close_out;
		if (n_mismatch == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			n_mismatch++;
			close_out();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("[FAIL] %0t got %h want %h", $time, got, exp);
		end
	endtask
	// ready and answer sampled mid-cycle, acted on at the next edge
	task automatic bus(input logic w, input logic [11:0] a,
		input logic [31:0] wd, output logic [31:0] d, output logic [1:0] r);
		logic ta, tw, tr, fin;
		if (w)
		begin
			{s_axi_awaddr, s_axi_wdata} <= {a, wd};
			{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		end
		else
		begin
			s_axi_araddr <= a;
			{s_axi_arvalid, s_axi_rready} <= 2'h3;
		end
		do
		begin
			@(negedge clk);
			ta = s_axi_awvalid && s_axi_awready;
			tw = s_axi_wvalid && s_axi_wready;
			tr = s_axi_arvalid && s_axi_arready;
			fin = w ? s_axi_bvalid : s_axi_rvalid;
			{d, r} = w ? {32'h0, s_axi_bresp} : {s_axi_rdata, s_axi_rresp};
			@(posedge clk);
			if (ta) s_axi_awvalid <= 1'b0;
			if (tw) s_axi_wvalid <= 1'b0;
			if (tr) s_axi_arvalid <= 1'b0;
		end
		while (!fin);
		{s_axi_bready, s_axi_rready} <= 2'h0;
		@(posedge clk);
	endtask
	task automatic acc(input logic w, input logic [11:0] a,
		input logic [31:0] v, input logic [31:0] e, input logic [1:0] er);
		logic [31:0] d;
		logic [1:0] r;
		bus(w, a, v, d, r);
		chk(d, e);
		chk({30'h0, r}, {30'h0, er});
	endtask
	task automatic ck_irq(input logic e);
		@(negedge clk);
		chk({31'h0, irq}, {31'h0, e});
		@(posedge clk);
	endtask
	task automatic cread(input logic [1:0] sz, input logic [17:0] a,
		input logic [31:0] e);
		logic g;
		cache_req <= '{1'b1, sz, a};
		do
		begin
			@(negedge clk);
			g = cache_gnt;
			chk({31'h0, cpu_fetch_stall}, 32'h1);
			@(posedge clk);
		end
		while (!g);
		cache_req.req <= 1'b0;
		do @(negedge clk); while (!cache_done);
		chk(cache_rdata, e);
		@(posedge clk);
	endtask
	task automatic nreq(input faecl_op_t op);
		logic g;
		nvpc_req <= '{1'b1, op, FAECL_SIZE_WORD, 18'h0, 32'h0, 1'b0, 1'b0};
		do
		begin
			@(negedge clk);
			g = nvpc_gnt;
			@(posedge clk);
		end
		while (!g);
		nvpc_req.req <= 1'b0;
		@(negedge clk);
		chk({29'h0, flash_cmd.sel, flash_cmd.op}, {30'h1, op});
		while (!nvpc_done) @(negedge clk);
		chk(nvpc_rdata, err);
		@(posedge clk);
	endtask
	initial
	begin
		logic [31:0] d;
		logic [1:0] r;
		{srst, ecc_enable, clk_en} <= 3'h7;
		{hub_wr_attempt, hub_wr_addr, lat, err} <= {19'h0, 4'h2, 32'h0};
		{cache_req, nvpc_req} <= '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h0;
		{s_axi_arvalid, s_axi_rready} <= 2'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= '0;
		repeat (5) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		acc(1'b0, FAECL_OFF_STATUS, 0, 0, 2'h0);
		acc(1'b0, FAECL_OFF_MASK, 0, 0, 2'h0);
		for (int i = 0; i < 3; i++)
			cread(i[1:0], 18'h00100, 32'h0);
		err <= 32'h1;
		cread(FAECL_SIZE_WORD, 18'h00444, 32'h0);
		err <= 32'h3;
		cread(FAECL_SIZE_WORD, 18'h00888, 32'h3);
		err <= 32'h0;
		acc(1'b0, FAECL_OFF_STATUS, 0, 32'h3, 2'h0);
		bus(1'b0, FAECL_OFF_LOG0, 0, d, r);
		chk(d & 32'h8003FFFF, 32'h80000444);
		bus(1'b0, FAECL_OFF_LOG0 + 12'h4, 0, d, r);
		chk(d & 32'h8003FFFF, 32'h80000888);
		acc(1'b0, FAECL_OFF_LOG0, 0, 0, 2'h0);
		acc(1'b0, FAECL_OFF_STATUS, 0, 0, 2'h0);
		{hub_wr_attempt, hub_wr_addr} <= {1'b1, 18'h2ABCD};
		@(posedge clk);
		hub_wr_attempt <= 1'b0;
		acc(1'b0, FAECL_OFF_STATUS, 0, 32'h4, 2'h0);
		ck_irq(1'b0);
		acc(1'b1, FAECL_OFF_MASK, 32'h4, 0, 2'h0);
		ck_irq(1'b1);
		acc(1'b0, FAECL_OFF_LOG0 + 12'h8, 0, 32'h8002ABCD, 2'h0);
		ck_irq(1'b0);
		acc(1'b1, FAECL_OFF_MASK, 32'hFFFFFFFF, 0, 2'h0);
		acc(1'b0, FAECL_OFF_MASK, 0, 32'h3F, 2'h0);
		acc(1'b0, 12'h040, 0, 0, 2'h2);
		acc(1'b1, 12'h044, 0, 0, 2'h2);
		acc(1'b1, FAECL_OFF_PROT, 32'h1, 0, 2'h0);
		nvpc_req <= '{1'b1, FAECL_OP_READ, FAECL_SIZE_WORD, 18'h00010,
			32'h0, 1'b1, 1'b0};
		@(negedge clk);
		chk({31'h0, nvpc_refused}, 32'h1);
		@(posedge clk);
		nvpc_req.req <= 1'b0;
		acc(1'b0, FAECL_OFF_LOG0 + 12'hC, 0, 32'h80000010, 2'h0);
		acc(1'b1, FAECL_OFF_PROT, 32'h0, 0, 2'h0);
		err <= 32'h1;
		cread(FAECL_SIZE_HALF, 18'h00030, 32'h0);
		ck_irq(1'b1);
		{err, lat} <= {32'h0, 4'h6};
		bus(1'b0, FAECL_OFF_LOG0, 0, d, r);
		ck_irq(1'b0);
		{clk_en, hub_wr_attempt} <= 2'h1;
		@(posedge clk);
		{clk_en, hub_wr_attempt} <= 2'h2;
		acc(1'b0, FAECL_OFF_STATUS, 0, 0, 2'h0);
		{ecc_enable, err} <= {1'b0, 32'h1};
		cread(FAECL_SIZE_WORD, 18'h00050, 32'h1);
		{ecc_enable, err} <= {1'b1, 32'h0};
		acc(1'b0, FAECL_OFF_STATUS, 0, 0, 2'h0);
		fork
			nreq(FAECL_OP_PROGRAM);
			begin
				repeat (2) @(posedge clk);
				cread(FAECL_SIZE_WORD, 18'h00010, 32'h0);
			end
		join
		fork
			cread(FAECL_SIZE_BYTE, 18'h00020, 32'h0);
			begin
				repeat (2) @(posedge clk);
				nreq(FAECL_OP_READ);
			end
		join
		err <= 32'h12345678;
		for (int i = 0; i < 4; i++)
			nreq(faecl_op_t'(i));
		close_out();
	end
endmodule
